// >>> hdl/relay_spi_pkg.sv
// shared constants and types for the relay driver serial target
// ----------------------------------------------------------------
// Functional notes
// - Commands come in on the serial input and answers go out on the serial output in one transfer.
// - The answer to a command is only sent during the next transfer, never the one carrying it.
// - After a register read the next answer is 10, the echoed address, then the register content (a read made during the reset reply gets diagnosis).
// - A transfer whose clock count is under 16 or not a multiple of 8 is erroneous and flagged next time.
// - After power-on or software reset the first answer is a reset reply, not a command answer.
// - A write starting 11 or a read starting 00 is a syntax error answered by standard diagnosis.
// - A read or write to a reserved or unused register is a syntax error, not an access.
// - A write is 10, 4-bit upper address, 2-bit lower address, 8 data bits; answered by diagnosis.
// - A read is 01, 4-bit upper address, 2-bit lower address, low bits are don't-care.
// - A frame starting 00 requests standard diagnosis, answered with a leading 0.
// - The transfer error flag sits at bit 10 and clears only after a 16, 24 or 32 clock transfer.
// - After reset the first answer carries the error flag and instruction reply, then diagnosis follows.
// ----------------------------------------------------------------
package relay_spi_pkg;

	localparam int FRAME_BITS = 16;
	localparam int DATA_BITS = 8;
	localparam int CNT_W = 6;
	localparam int PREFIX_LSB = 14;
	localparam int ADDR_LSB = 8;
	localparam int ADDR_BITS = 6;
	localparam int ERR_FLAG_BIT = 10;
	localparam logic [CNT_W-1:0] MIN_CLOCKS = 6'h10;
	localparam logic [CNT_W-1:0] MAX_CLOCKS = 6'h20;
	localparam logic [CNT_W-1:0] CNT_MAX = 6'h3F;
	localparam logic [2:0] BYTE_ALIGN = 3'h0;
	localparam logic [1:0] WRITE_PREFIX = 2'h2;
	localparam logic [1:0] READ_PREFIX = 2'h1;
	localparam logic [1:0] READ_REPLY_PREFIX = 2'h2;
	localparam logic [1:0] BAD_WRITE_PREFIX = 2'h3;
	localparam logic [1:0] BAD_READ_PREFIX = 2'h0;
	localparam logic ERR_FLAG_RESET = 1'b1;
	localparam logic [FRAME_BITS-1:0] SHIFT_RESET = 16'h0000;
	localparam logic [63:0] ADDR_USED_DEFAULT = 64'hFFFF_FFFF_FFFF_FFFF;

	typedef struct packed {
		logic [3:0] address_upper_field;
		logic [1:0] address_lower_field;
	} reg_addr_s;

	typedef struct packed {
		reg_addr_s addr;
		logic [DATA_BITS-1:0] data;
	} reg_write_s;

	typedef struct packed {
		logic chip_select_low;
		logic sclk;
		logic si;
	} spi_pins_s;

	localparam spi_pins_s PINS_IDLE = 3'h4;
	localparam reg_addr_s ADDR_RESET = 6'h00;
	localparam reg_write_s WRITE_RESET = 14'h0000;

	typedef enum logic [1:0] {
		ANS_RESET,
		ANS_DIAG,
		ANS_READ
	} answer_e;

endpackage

// >>> hdl/spi_pin_sync.sv
// two-stage synchroniser for the serial pins
`timescale 1ns/100ps
module spi_pin_sync
	import relay_spi_pkg::*;
(
	input logic mclk,
	input logic rst,
	input spi_pins_s pins_in,
	output spi_pins_s pins_sync
);

	localparam int PIN_COUNT = $bits(spi_pins_s);

	genvar i;
	generate
		for (i = 0; i < PIN_COUNT; i++)
		begin : g_pin
			logic meta_q;
			logic sync_q;
			always_ff @(posedge mclk)
			begin
				if (rst)
				begin
					meta_q <= PINS_IDLE[i];
					sync_q <= PINS_IDLE[i];
				end
				else
				begin
					meta_q <= pins_in[i];
					sync_q <= meta_q;
				end
			end
			assign pins_sync[i] = sync_q;
		end
	endgenerate

endmodule

// >>> hdl/relay_spi_target.sv
// serial frame engine of the relay driver: shift, decode, answer selection
`timescale 1ns/100ps
module relay_spi_target
	import relay_spi_pkg::*;
#(
	parameter logic [63:0] ADDR_USED_MAP = ADDR_USED_DEFAULT
)
(
	input logic mclk,
	input logic rst,
	input spi_pins_s pins,
	input logic soft_reset,
	input logic [FRAME_BITS-2:0] diag_status,
	input logic [DATA_BITS-1:0] instruction_reply,
	input logic [DATA_BITS-1:0] rd_data,
	output logic so,
	output logic so_oe,
	output logic wr_strobe,
	output reg_write_s wr_req,
	output reg_addr_s rd_addr,
	output logic diag_taken
);

	// ----------------------------------------------------------------
	// pin sampling and edge detection
	// ----------------------------------------------------------------
	spi_pins_s pins_s;
	spi_pins_s prev_q;

	spi_pin_sync u_sync (
		.mclk(mclk),
		.rst(rst),
		.pins_in(pins),
		.pins_sync(pins_s)
	);

	always_ff @(posedge mclk)
	begin
		if (rst)
			prev_q <= PINS_IDLE;
		else
			prev_q <= pins_s;
	end

	wire cs_active = ~pins_s.chip_select_low;
	wire cs_fall = prev_q.chip_select_low & ~pins_s.chip_select_low;
	wire cs_rise = ~prev_q.chip_select_low & pins_s.chip_select_low;
	wire sclk_fall = cs_active & prev_q.sclk & ~pins_s.sclk;

	// ----------------------------------------------------------------
	// frame state
	// ----------------------------------------------------------------
	logic [FRAME_BITS-1:0] sr_q;
	logic [CNT_W-1:0] cnt_q;
	logic err_flag_q;
	answer_e ans_q;
	logic so_q;
	logic so_oe_q;
	logic wr_strobe_q;
	reg_write_s wr_req_q;
	reg_addr_s rd_addr_q;
	logic diag_taken_q;

	// ----------------------------------------------------------------
	// decode of the frame held at chip select release
	// ----------------------------------------------------------------
	wire [1:0] prefix = sr_q[PREFIX_LSB +: 2];
	wire reg_addr_s frame_addr = sr_q[ADDR_LSB +: ADDR_BITS];
	wire [FRAME_BITS-3:0] frame_body = sr_q[FRAME_BITS-3:0];
	wire addr_used = ADDR_USED_MAP[frame_addr];
	// 16, 24 or 32 clocks; the counter saturates so long bursts stay bad
	wire frame_ok = (cnt_q >= MIN_CLOCKS) && (cnt_q <= MAX_CLOCKS)
		&& (cnt_q[2:0] == BYTE_ALIGN);
	wire is_write = frame_ok && (prefix == WRITE_PREFIX) && addr_used;
	wire is_read = frame_ok && (prefix == READ_PREFIX) && addr_used;
	// bad prefixes, unused addresses and diagnosis requests all get diagnosis
	wire answer_e next_ans = (is_read && ans_q != ANS_RESET) ? ANS_READ : ANS_DIAG;

	// ----------------------------------------------------------------
	// answer words
	// ----------------------------------------------------------------
	wire [FRAME_BITS-1:0] diag_word = {1'b0, diag_status[14:11], err_flag_q,
		diag_status[9:0]};
	wire [FRAME_BITS-1:0] read_word = {READ_REPLY_PREFIX, rd_addr_q, rd_data};
	wire [FRAME_BITS-1:0] reset_word = {1'b1, 4'h0, ERR_FLAG_RESET, 2'h0,
		instruction_reply};
	logic [FRAME_BITS-1:0] reply_word;

	always_comb
	begin
		unique case (ans_q)
			ANS_RESET: reply_word = reset_word;
			ANS_DIAG: reply_word = diag_word;
			ANS_READ: reply_word = read_word;
			default: reply_word = diag_word;
		endcase
	end

	// ----------------------------------------------------------------
	// shift register and clock counter
	// ----------------------------------------------------------------
	// one register serves both directions, so extra bytes pass straight
	// through for chained devices
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			sr_q <= SHIFT_RESET;
			so_q <= 1'b0;
		end
		else if (cs_fall)
		begin
			sr_q <= reply_word;
			so_q <= reply_word[FRAME_BITS-1];
		end
		else if (sclk_fall)
		begin
			sr_q <= {sr_q[FRAME_BITS-2:0], pins_s.si};
			so_q <= sr_q[FRAME_BITS-2];
		end
	end

	always_ff @(posedge mclk)
	begin
		if (rst || cs_fall)
			cnt_q <= '0;
		else if (sclk_fall && cnt_q != CNT_MAX)
			cnt_q <= cnt_q + 6'h01;
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
			so_oe_q <= 1'b0;
		else
			so_oe_q <= cs_active;
	end

	// ----------------------------------------------------------------
	// answer selection and transfer error flag
	// ----------------------------------------------------------------
	// a reset request beats a frame ending in the same cycle
	always_ff @(posedge mclk)
	begin
		if (rst || soft_reset)
		begin
			ans_q <= ANS_RESET;
			err_flag_q <= ERR_FLAG_RESET;
		end
		else if (cs_rise)
		begin
			ans_q <= next_ans;
			err_flag_q <= ~frame_ok;
		end
	end

	// ----------------------------------------------------------------
	// requests toward the register bank
	// ----------------------------------------------------------------
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			wr_strobe_q <= 1'b0;
			wr_req_q <= WRITE_RESET;
			rd_addr_q <= ADDR_RESET;
			diag_taken_q <= 1'b0;
		end
		else
		begin
			wr_strobe_q <= cs_rise && is_write;
			diag_taken_q <= cs_fall && ans_q == ANS_DIAG;
			if (cs_rise && is_write)
				wr_req_q <= frame_body;
			if (cs_rise && is_read)
				rd_addr_q <= frame_addr;
		end
	end

	assign so = so_q;
	assign so_oe = so_oe_q;
	assign wr_strobe = wr_strobe_q;
	assign wr_req = wr_req_q;
	assign rd_addr = rd_addr_q;
	assign diag_taken = diag_taken_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	sequence frame_end_s;
		cs_rise && !soft_reset;
	endsequence

	sequence load_s(answer_e kind);
		cs_fall && !soft_reset && ans_q == kind;
	endsequence

	answer_stable_a: assert property (!cs_rise && !soft_reset |=> $stable(ans_q))
		else $error("answer kind changed inside a transfer");

	read_echo_a: assert property (load_s(ANS_READ) |=> so_q
		&& sr_q[FRAME_BITS-1 -: 2] == READ_REPLY_PREFIX
		&& sr_q[ADDR_LSB +: ADDR_BITS] == rd_addr_q)
		else $error("read answer lacks prefix or address echo");

	bad_count_a: assert property (frame_end_s ##0 !frame_ok |=> err_flag_q
		&& ans_q == ANS_DIAG && !wr_strobe_q)
		else $error("bad clock count not flagged");

	soft_reset_a: assert property (soft_reset |=> ans_q == ANS_RESET && err_flag_q)
		else $error("reset reply not armed");

	syntax_a: assert property (frame_end_s ##0 frame_ok
		&& (prefix == BAD_WRITE_PREFIX || prefix == BAD_READ_PREFIX)
		|=> !wr_strobe_q && ans_q == ANS_DIAG)
		else $error("bad command prefix accepted");

	unused_addr_a: assert property (frame_end_s ##0 !addr_used
		|=> !wr_strobe_q && ans_q != ANS_READ)
		else $error("unused register was accessed");

	write_take_a: assert property (frame_end_s ##0 is_write |=> wr_strobe_q
		&& wr_req_q == $past(frame_body) && ans_q == ANS_DIAG)
		else $error("write frame not delivered");

	diag_lead_a: assert property (load_s(ANS_DIAG) |=> !so_q
		&& sr_q[ERR_FLAG_BIT] == err_flag_q && diag_taken_q)
		else $error("diagnosis answer malformed");

	reset_word_a: assert property (load_s(ANS_RESET) |=> so_q
		&& sr_q[ERR_FLAG_BIT]
		&& sr_q[DATA_BITS-1:0] == $past(instruction_reply))
		else $error("reset reply malformed");

	after_reset_a: assert property (frame_end_s ##0 ans_q == ANS_RESET
		|=> ans_q == ANS_DIAG ##1 $stable(ans_q))
		else $error("second answer after reset is not diagnosis");

	so_enable_a: assert property (cs_fall |=> so_oe_q ##1 (so_oe_q == cs_active))
		else $error("serial output enable does not follow chip select");

	so_release_a: assert property (cs_rise |=> !so_oe_q)
		else $error("serial output still driven after release");

endmodule

// >>> dv/spi_master_model.sv
// serial master model driving the relay driver pins
`timescale 1ns/100ps
module spi_master_model
	import relay_spi_pkg::*;
(
	input logic mclk,
	input logic so,
	input logic so_oe,
	output spi_pins_s pins
);
	initial pins = PINS_IDLE;
	// sclk idles low, si moves on the rise, so is taken just before the fall
	// callers keep their previous command to decode each answer
	task automatic xfer(input logic [31:0] tx, input int n, output logic [15:0] rx);
		int i;
		rx = 16'hFFFF;
		@(posedge mclk) pins <= 3'h0;
		repeat (8) @(posedge mclk);
		for (i = n - 1; i >= 0; i--)
		begin
			pins <= {1'b0, 1'b1, tx[i]};
			repeat (4) @(posedge mclk);
			// a released line reads as z and never matches
			if (i >= n - 16)
				rx[i - n + 16] = so_oe ? so : 1'bz;
			pins <= {1'b0, 1'b0, tx[i]};
			repeat (4) @(posedge mclk);
		end
		repeat (4) @(posedge mclk);
		pins <= PINS_IDLE;
		repeat (10) @(posedge mclk);
	endtask
endmodule

// >>> dv/relay_spi_target_tb_top.sv
// self-checking bench for the relay driver serial target
`timescale 1ns/100ps
module relay_spi_target_tb_top;
	import relay_spi_pkg::*;
	localparam logic [14:0] DIAG = 15'h5A3C;
	localparam logic [7:0] INSTR_CODE = 8'hC3;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic soft_reset = 1'b0;
	logic [7:0] rd_data = 8'h00;
	logic so;
	logic so_oe;
	logic wr_strobe;
	logic diag_taken;
	spi_pins_s pins;
	reg_write_s wr_req;
	reg_addr_s rd_addr;
	logic [15:0] rx;
	int mismatches = 0;
	int n_tests = 0;
	int n_wr = 0;
	int n_diag = 0;
	always #12.5 mclk = ~mclk;
	// ----------------------------------------
	// core side stand-in
	// ----------------------------------------
	always @(posedge mclk)
		rd_data <= {rd_addr, 2'b11} ^ 8'h5A;
	always @(posedge mclk)
		if (wr_strobe === 1'b1)
			n_wr <= n_wr + 1;
	always @(posedge mclk)
		if (diag_taken === 1'b1)
			n_diag <= n_diag + 1;
	// address 63 left unused to reach the refusal path
	relay_spi_target #(.ADDR_USED_MAP(64'h7FFF_FFFF_FFFF_FFFF)) relay_spi_target_instruction_reply (
		.mclk(mclk), .rst(rst), .pins(pins), .soft_reset(soft_reset),
		.diag_status(DIAG), .instruction_reply(INSTR_CODE), .rd_data(rd_data),
		.so(so), .so_oe(so_oe), .wr_strobe(wr_strobe), .wr_req(wr_req),
		.rd_addr(rd_addr), .diag_taken(diag_taken));
	spi_master_model spi_master_model_instruction_reply (
		.mclk(mclk), .so(so), .so_oe(so_oe), .pins(pins));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [15:0] diag(input logic err);
		return {1'b0, DIAG[14:11], err, DIAG[9:0]};
	endfunction
	function automatic logic [15:0] rd_exp(input logic [5:0] a);
		return {2'b10, a, {a, 2'b11} ^ 8'h5A};
	endfunction
	task automatic check(input logic [15:0] got, input logic [15:0] exp, input string msg);
		n_tests++;
		if (got !== exp)
		begin
			mismatches++;
			$display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
		end
	endtask
	task automatic xf(input logic [31:0] tx, input int n);
		spi_master_model_instruction_reply.xfer(tx, n, rx);
		check({15'h0, so_oe}, 16'h0, "output released");
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		int d;
		d = n_diag;
		xf(32'h4E00, 16);
		check(rx, {8'h84, INSTR_CODE}, "reset reply");
		xf(32'h0, 16);
		check(rx, diag(1'b0), "second frame");
		check(16'(n_diag - d), 16'h1, "diagnosis pulses");
		$display("test reset done");
	endtask
	task automatic t_write();
		int w;
		w = n_wr;
		xf(32'h9696, 16);
		check(16'(n_wr - w), 16'h1, "strobe count");
		check({2'b00, wr_req}, 16'h1696, "write fields");
		xf(32'h6900, 16);
		check(rx, diag(1'b0), "write answer");
		check({10'h0, rd_addr}, 16'h0029, "read address");
		xf(32'h4EFF, 16);
		check(rx, rd_exp(6'h29), "first read answer");
		xf(32'h0, 16);
		check(rx, rd_exp(6'h0E), "second read answer");
		xf(32'h0, 16);
		check(rx, diag(1'b0), "diagnosis answer");
		$display("test write read done");
	endtask
	task automatic t_len();
		int lens[5] = '{12, 20, 24, 32, 17};
		logic errs[5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
		foreach (lens[k])
		begin
			xf(32'h0, lens[k]);
			xf(32'h0, 16);
			check(rx, diag(errs[k]), "error flag");
		end
		xf(32'h0069_00, 24);
		xf(32'h0, 16);
		check(rx, rd_exp(6'h29), "padded read");
		$display("test length done");
	endtask
	task automatic t_syntax();
		logic [15:0] cmds[4] = '{16'hD696, 16'h3F00, 16'hBF55, 16'h7F00};
		int w;
		foreach (cmds[k])
		begin
			w = n_wr;
			xf({16'h0, cmds[k]}, 16);
			xf(32'h0, 16);
			check(rx, diag(1'b0), "syntax answer");
			check(16'(n_wr - w), 16'h0, "no write");
		end
		$display("test syntax done");
	endtask
	task automatic t_soft();
		@(posedge mclk) soft_reset <= 1'b1;
		@(posedge mclk) soft_reset <= 1'b0;
		xf(32'h6900, 16);
		check(rx, {8'h84, INSTR_CODE}, "soft reset reply");
		xf(32'h0, 16);
		check(rx, diag(1'b0), "after soft reset");
		$display("test soft reset done");
	endtask
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// ----------------------------------------
	// sequence and watchdog
	// ----------------------------------------
	initial
	begin
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		repeat (4) @(posedge mclk);
		t_reset();
		t_write();
		t_len();
		t_syntax();
		t_soft();
		test_done();
	end
	// about 4650 cycles expected, over eight times that allowed
	initial
	begin
		#1000000;
		mismatches++;
		test_done();
	end
endmodule
